// [design/aeu_mode_dec.sv]
// Decoder of byte counts and address source for each addressing mode.
`timescale 1ns/1ns
`default_nettype none
module aeu_mode_dec
    import aeu_pkg::*;
(
    // Decode request and answer.
    aeu_dec_if.dec d
);

    // Look up lengths per mode; long forms are refused for memory-to-memory work.
    always_comb
    begin
        d.nbytes    = LEN_0;
        d.ptr_bytes = LEN_0;
        d.src       = SRC_NONE;
        d.illegal   = 1'b0;
        unique case (d.mode)
            // Opcode alone; nothing follows.
            M_INHERENT: d.src = SRC_NONE;
            // One operand value byte.
            M_IMMEDIATE:
            begin
                d.nbytes = LEN_1;
                d.src    = SRC_INSTR;
            end
            // One page-zero address or short offset byte.
            M_DIR_SHORT, M_IDX_SHORT, M_BIT_DIRECT:
            begin
                d.nbytes = LEN_1;
                d.src    = SRC_INSTR;
            end
            // Two address or offset bytes; refused for memory-to-memory work.
            M_DIR_LONG, M_IDX_LONG:
            begin
                d.nbytes  = LEN_2;
                d.src     = SRC_INSTR;
                d.illegal = d.rmw;
            end
            // Index register alone.
            M_IDX_NONE: d.src = SRC_INSTR;
            // Pointer address byte, byte-wide pointer.
            M_IND_SHORT, M_INDIDX_SHORT, M_BIT_INDIRECT:
            begin
                d.nbytes    = LEN_1;
                d.ptr_bytes = LEN_1;
                d.src       = SRC_POINTER;
            end
            // Pointer address byte, word-wide pointer.
            M_IND_LONG, M_INDIDX_LONG:
            begin
                d.nbytes    = LEN_1;
                d.ptr_bytes = LEN_2;
                d.src       = SRC_POINTER;
                d.illegal   = d.rmw;
            end
            // Offset byte follows the opcode.
            M_REL_DIRECT:
            begin
                d.nbytes = LEN_1;
                d.src    = SRC_PC_REL;
            end
            // Offset byte lies in page zero at the address that follows.
            M_REL_INDIRECT:
            begin
                d.nbytes    = LEN_1;
                d.ptr_bytes = LEN_1;
                d.src       = SRC_PC_REL;
            end
            // Unused code.
            default: d.illegal = 1'b1;
        endcase
        // A refused mode fetches nothing.
        if (d.illegal)
        begin
            d.nbytes    = LEN_0;
            d.ptr_bytes = LEN_0;
            d.src       = SRC_NONE;
        end
    end

endmodule
`default_nettype wire

// [design/aeu_top.sv]
// Effective-address and instruction-length unit of the 8-bit core.
// Functional notes
// - Inherent instruction is one byte, no fetch.
// - Immediate takes operand from following byte.
// - Short direct uses one page-zero address byte.
// - Long direct takes two address bytes.
// - Indexed address is unsigned index plus offset.
// - No-offset indexed fetches nothing, uses index.
// - Short indexed adds byte offset, up to 1FE.
// - Long indexed adds index to word offset.
// - Indirect reads pointer from page zero.
// - Short indirect: byte pointer, one byte after.
// - Long indirect: word pointer, one byte after.
// - Short forms stay within page zero, except indexed ones (up to 1FE).
// - Long forms reach whole space, more bytes.
// - Memory-to-memory operations refuse long forms.
// - Relative target counts from next instruction.
// - Inherent set has wait and halt operations.
// - Relative adds signed byte, direct or indirect.
// - Short indirect indexed adds index to pointer.
`timescale 1ns/1ns
`default_nettype none
module aeu_top
    import aeu_pkg::*;
(
    // Clock and reset.
    input  wire logic              CLK,
    input  wire logic              RSTN,
    // Instruction request from the fetch unit.
    input  wire logic              START,
    input  wire logic [3:0]        MODE,
    input  wire logic [2:0]        INH_OP,
    input  wire logic              IDX_SEL,
    input  wire logic              RMW,
    input  wire logic [ADDR_W-1:0] OPC_ADDR,
    input  wire logic [DATA_W-1:0] IDX_X,
    input  wire logic [DATA_W-1:0] IDX_Y,
    // Memory read port.
    output var  logic              MEM_REQ,
    output var  logic [ADDR_W-1:0] MEM_ADDR,
    input  wire logic [DATA_W-1:0] MEM_RDATA,
    input  wire logic              MEM_ACK,
    // Result of the decode.
    output var  logic              BUSY,
    output var  logic              DONE,
    output var  logic [ADDR_W-1:0] EA,
    output var  logic [DATA_W-1:0] OPERAND,
    output var  logic [1:0]        OPND_BYTES,
    output var  logic [1:0]        EA_SRC,
    output var  logic [ADDR_W-1:0] NEXT_PC,
    output var  logic              BAD_MODE,
    // Inherent operation strobes.
    output var  logic              WAIT_REQ,
    output var  logic              HALT_REQ,
    output var  logic              MASK_SET,
    output var  logic              MASK_CLR,
    output var  logic              SP_RESET
);

    aeu_regs_t         r_r;       // Registered state.
    aeu_regs_t         r_nxt;     // Next state.
    aeu_dec_if         dec_if (); // Link to the mode decoder.
    logic              take;      // A request is accepted this cycle.
    logic [ADDR_W-1:0] op_word;   // Two instruction bytes as a word.
    logic [ADDR_W-1:0] ptr_word;  // Two pointer bytes as a word.

    // Mode decoder.
    aeu_mode_dec u_dec (
        .d (dec_if)
    );

    // The decoder looks at the incoming mode while idle, else the held one.
    always_comb
    begin
        dec_if.mode = (r_r.state == S_IDLE) ? aeu_mode_t'(MODE) : r_r.mode;
        dec_if.rmw  = RMW;
    end

    // Request acceptance and word assembly, high byte at the lower address.
    assign take     = START && (r_r.state == S_IDLE);
    assign op_word  = {r_r.opb[0], r_r.opb[1]};
    assign ptr_word = {r_r.ptb[0], r_r.ptb[1]};

    // Sequencer: fetch operand bytes, then pointer bytes, then form the address.
    always_comb
    begin
        r_nxt          = r_r;
        r_nxt.done     = 1'b0;
        r_nxt.wait_req = 1'b0;
        r_nxt.halt_req = 1'b0;
        r_nxt.mask_set = 1'b0;
        r_nxt.mask_clr = 1'b0;
        r_nxt.sp_reset = 1'b0;
        unique case (r_r.state)
            // Wait for a request and latch everything it carries.
            S_IDLE:
            begin
                if (START)
                begin
                    r_nxt.busy    = 1'b1;
                    r_nxt.pc      = OPC_ADDR;
                    r_nxt.mode    = aeu_mode_t'(MODE);
                    r_nxt.inh     = aeu_inh_t'(INH_OP);
                    r_nxt.idx     = IDX_SEL ? IDX_Y : IDX_X;
                    r_nxt.cnt     = LEN_0;
                    r_nxt.opb     = '0;
                    r_nxt.ptb     = '0;
                    r_nxt.nbytes  = dec_if.nbytes;
                    r_nxt.ptr_n   = dec_if.ptr_bytes;
                    r_nxt.src     = dec_if.src;
                    r_nxt.bad     = dec_if.illegal;
                    r_nxt.next_pc = OPC_ADDR + STEP_1 + {14'h0000, dec_if.nbytes};
                    if (dec_if.nbytes == LEN_0)
                    begin
                        // Nothing to fetch: form the address at once.
                        r_nxt.state = S_CALC;
                    end
                    else
                    begin
                        // First byte after the opcode.
                        r_nxt.state    = S_FETCH;
                        r_nxt.mem_req  = 1'b1;
                        r_nxt.mem_addr = OPC_ADDR + STEP_1;
                    end
                end
            end
            // Read the bytes that follow the opcode.
            S_FETCH:
            begin
                if (MEM_ACK)
                begin
                    r_nxt.opb[r_r.cnt[0]] = MEM_RDATA;
                    r_nxt.cnt             = 2'(r_r.cnt + LEN_1);
                    if (2'(r_r.cnt + LEN_1) == r_r.nbytes)
                    begin
                        if (r_r.ptr_n != LEN_0)
                        begin
                            // The byte just read addresses a page-zero pointer.
                            r_nxt.state    = S_PTR;
                            r_nxt.cnt      = LEN_0;
                            r_nxt.mem_addr = {PAGE0_HI, MEM_RDATA};
                        end
                        else
                        begin
                            // All bytes are in.
                            r_nxt.state   = S_CALC;
                            r_nxt.mem_req = 1'b0;
                        end
                    end
                    else
                    begin
                        // Next byte sits at the next address.
                        r_nxt.mem_addr = r_r.mem_addr + STEP_1;
                    end
                end
            end
            // Read the pointer, one byte or a high/low word.
            S_PTR:
            begin
                if (MEM_ACK)
                begin
                    r_nxt.ptb[r_r.cnt[0]] = MEM_RDATA;
                    r_nxt.cnt             = 2'(r_r.cnt + LEN_1);
                    if (2'(r_r.cnt + LEN_1) == r_r.ptr_n)
                    begin
                        r_nxt.state   = S_CALC;
                        r_nxt.mem_req = 1'b0;
                    end
                    else
                    begin
                        // Low byte of a word pointer follows the high byte.
                        r_nxt.mem_addr = r_r.mem_addr + STEP_1;
                    end
                end
            end
            // Form the address, report it, and return to idle.
            S_CALC:
            begin
                r_nxt.state   = S_IDLE;
                r_nxt.busy    = 1'b0;
                r_nxt.done    = 1'b1;
                r_nxt.operand = r_r.opb[0];
                unique case (r_r.mode)
                    // Operand is the byte after the opcode.
                    M_IMMEDIATE: r_nxt.ea = r_r.pc + STEP_1;
                    // Page-zero address in one byte.
                    M_DIR_SHORT, M_BIT_DIRECT: r_nxt.ea = {PAGE0_HI, r_r.opb[0]};
                    // Full address in two bytes.
                    M_DIR_LONG: r_nxt.ea = op_word;
                    // Index register alone.
                    M_IDX_NONE: r_nxt.ea = {PAGE0_HI, r_r.idx};
                    // Byte offset plus index, carry kept into bit 8.
                    M_IDX_SHORT: r_nxt.ea = aeu_idx_add({PAGE0_HI, r_r.opb[0]}, r_r.idx);
                    // Word offset plus index.
                    M_IDX_LONG: r_nxt.ea = aeu_idx_add(op_word, r_r.idx);
                    // Byte pointer from page zero.
                    M_IND_SHORT, M_BIT_INDIRECT: r_nxt.ea = {PAGE0_HI, r_r.ptb[0]};
                    // Word pointer from page zero.
                    M_IND_LONG: r_nxt.ea = ptr_word;
                    // Byte pointer plus index.
                    M_INDIDX_SHORT: r_nxt.ea = aeu_idx_add({PAGE0_HI, r_r.ptb[0]}, r_r.idx);
                    // Word pointer plus index.
                    M_INDIDX_LONG: r_nxt.ea = aeu_idx_add(ptr_word, r_r.idx);
                    // Signed offset from the next instruction.
                    M_REL_DIRECT: r_nxt.ea = aeu_rel(r_r.next_pc, r_r.opb[0]);
                    // Signed offset read through the pointer.
                    M_REL_INDIRECT: r_nxt.ea = aeu_rel(r_r.next_pc, r_r.ptb[0]);
                    // Inherent and illegal codes carry no address.
                    default: r_nxt.ea = '0;
                endcase
                if (r_r.bad)
                begin
                    // A refused mode reports a zero address.
                    r_nxt.ea = '0;
                end
                if (r_r.mode == M_INHERENT)
                begin
                    // Strobe the inherent operations the core acts on.
                    r_nxt.wait_req = (r_r.inh == INH_WAIT_FOR_INTERRUPT_OP);
                    r_nxt.halt_req = (r_r.inh == INH_HALT_OP);
                    r_nxt.mask_set = (r_r.inh == INH_SET_INTERRUPT_MASK_OP);
                    r_nxt.mask_clr = (r_r.inh == INH_CLEAR_INTERRUPT_MASK_OP);
                    r_nxt.sp_reset = (r_r.inh == INH_STACK_POINTER_RESET_OP);
                end
            end
        endcase
    end

    // State register; reset puts every field at zero and the sequencer idle.
    always_ff @(posedge CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            r_r <= '0;
        end
        else
        begin
            r_r <= r_nxt;
        end
    end

    // Outputs come straight from the state register.
    assign MEM_REQ    = r_r.mem_req;
    assign MEM_ADDR   = r_r.mem_addr;
    assign BUSY       = r_r.busy;
    assign DONE       = r_r.done;
    assign EA         = r_r.ea;
    assign OPERAND    = r_r.operand;
    assign OPND_BYTES = r_r.nbytes;
    assign EA_SRC     = r_r.src;
    assign NEXT_PC    = r_r.next_pc;
    assign BAD_MODE   = r_r.bad;
    assign WAIT_REQ   = r_r.wait_req;
    assign HALT_REQ   = r_r.halt_req;
    assign MASK_SET   = r_r.mask_set;
    assign MASK_CLR   = r_r.mask_clr;
    assign SP_RESET   = r_r.sp_reset;

    // An inherent request finishes two cycles on without touching memory.
    a_inh_no_fetch: assert property (
        @(posedge CLK) disable iff (!RSTN)
        take && (MODE == M_INHERENT) |-> !MEM_REQ ##1 !MEM_REQ ##1 (DONE && OPND_BYTES == LEN_0))
        else $error("inherent request fetched bytes or finished late");

    // Immediate operand sits right after the opcode.
    a_imm_operand: assert property (
        @(posedge CLK) disable iff (!RSTN)
        take && (MODE == M_IMMEDIATE) |=> MEM_REQ && (MEM_ADDR == $past(OPC_ADDR) + STEP_1))
        else $error("immediate operand not fetched from the next address");

    // Short direct results stay in page zero.
    a_short_page0: assert property (
        @(posedge CLK) disable iff (!RSTN)
        DONE && (r_r.mode == M_DIR_SHORT) |-> (EA[15:8] == PAGE0_HI) && (OPND_BYTES == LEN_1))
        else $error("short direct address left page zero");

    // Long direct and long indexed forms, when not refused, report two bytes after the opcode.
    a_long_two_bytes: assert property (
        @(posedge CLK) disable iff (!RSTN)
        DONE && !BAD_MODE && (r_r.mode inside {M_DIR_LONG, M_IDX_LONG}) |-> OPND_BYTES == LEN_2)
        else $error("long form length not two bytes");

    // Short indexed sum never passes the top of its range.
    a_idx_short_rng: assert property (
        @(posedge CLK) disable iff (!RSTN)
        DONE && (r_r.mode inside {M_IDX_SHORT, M_INDIDX_SHORT}) |-> EA <= SHORT_IDX_TOP)
        else $error("short indexed address out of range");

    // Memory-to-memory work in a long form is refused without a fetch.
    a_rmw_long_bad: assert property (
        @(posedge CLK) disable iff (!RSTN)
        take && RMW && (MODE inside {M_DIR_LONG, M_IDX_LONG, M_IND_LONG, M_INDIDX_LONG})
        |=> !MEM_REQ ##1 (DONE && BAD_MODE))
        else $error("long form accepted for memory-to-memory work");

    // The first pointer read lands in page zero.
    a_ptr_page0: assert property (
        @(posedge CLK) disable iff (!RSTN)
        (r_r.state == S_FETCH) && MEM_ACK && (r_r.ptr_n != LEN_0)
        |=> MEM_REQ && (MEM_ADDR[15:8] == PAGE0_HI) && (MEM_ADDR[7:0] == $past(MEM_RDATA)))
        else $error("pointer not read from page zero");

    // The low byte of an operand word is read one address above the high byte.
    a_word_order: assert property (
        @(posedge CLK) disable iff (!RSTN)
        MEM_REQ && MEM_ACK && (r_r.state == S_FETCH) && (r_r.cnt == LEN_0)
        && (r_r.nbytes == LEN_2) |=> MEM_REQ && (MEM_ADDR == $past(MEM_ADDR) + STEP_1))
        else $error("second byte of a word not at the next address");

    // Relative target is the next instruction plus the signed offset.
    a_rel_target: assert property (
        @(posedge CLK) disable iff (!RSTN)
        DONE && (r_r.mode == M_REL_DIRECT)
        |-> (EA == NEXT_PC + {{REL_EXT_W{OPERAND[7]}}, OPERAND})
            && (NEXT_PC == r_r.pc + STEP_1 + STEP_1))
        else $error("relative target wrong");

    // Halt strobe comes with the end of an inherent halt.
    a_halt_strobe: assert property (
        @(posedge CLK) disable iff (!RSTN)
        take && (MODE == M_INHERENT) && (INH_OP == INH_HALT_OP) |-> ##2 (HALT_REQ && DONE))
        else $error("halt operation not strobed");

endmodule
`default_nettype wire

// [inc/aeu_dec_if.sv]
// Interface between the sequencer and the addressing-mode decoder.
`timescale 1ns/1ns
`default_nettype none
interface aeu_dec_if import aeu_pkg::*; ();
    aeu_mode_t  mode;      // Mode to decode.
    logic       rmw;       // Memory-to-memory read-modify-write operation.
    logic [1:0] nbytes;    // Bytes after the opcode.
    logic [1:0] ptr_bytes; // Bytes of the pointer read from page zero.
    aeu_src_t   src;       // Source of the effective address.
    logic       illegal;   // Mode cannot be used.

    // Decoder side.
    modport dec (input mode, input rmw, output nbytes, output ptr_bytes,
                 output src, output illegal);
    // Sequencer side.
    modport core (output mode, output rmw, input nbytes, input ptr_bytes,
                  input src, input illegal);
endinterface
`default_nettype wire

// [inc/aeu_pkg.sv]
// Shared types, constants and helpers for the addressing-mode effective-address unit.
`default_nettype none
package aeu_pkg;
    // Address and data widths of the core.
    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;
    // Byte counts that follow the opcode.
    localparam logic [1:0] LEN_0 = 2'h0;
    localparam logic [1:0] LEN_1 = 2'h1;
    localparam logic [1:0] LEN_2 = 2'h2;
    // High byte of every page-zero address.
    localparam logic [7:0] PAGE0_HI = 8'h00;
    // Address step between consecutive bytes.
    localparam logic [15:0] STEP_1 = 16'h0001;
    // Highest address a byte plus an index can reach.
    localparam logic [15:0] SHORT_IDX_TOP = 16'h01fe;
    // Width of the sign extension of a relative offset.
    localparam int REL_EXT_W = 8;

    // Addressing modes, in port code order; code 4'hf is illegal.
    typedef enum logic [3:0] {
        M_INHERENT, M_IMMEDIATE, M_DIR_SHORT, M_DIR_LONG,
        M_IDX_NONE, M_IDX_SHORT, M_IDX_LONG, M_IND_SHORT,
        M_IND_LONG, M_INDIDX_SHORT, M_INDIDX_LONG, M_REL_DIRECT,
        M_REL_INDIRECT, M_BIT_DIRECT, M_BIT_INDIRECT
    } aeu_mode_t;

    // Inherent operations that the unit reports to the core.
    typedef enum logic [2:0] {
        INH_OTHER, INH_WAIT_FOR_INTERRUPT_OP, INH_HALT_OP,
        INH_SET_INTERRUPT_MASK_OP, INH_CLEAR_INTERRUPT_MASK_OP,
        INH_STACK_POINTER_RESET_OP
    } aeu_inh_t;

    // Where the effective address comes from.
    typedef enum logic [1:0] {
        SRC_NONE, SRC_INSTR, SRC_POINTER, SRC_PC_REL
    } aeu_src_t;

    // Sequencer states.
    typedef enum logic [1:0] {S_IDLE, S_FETCH, S_PTR, S_CALC} aeu_state_t;

    // Complete state of the unit.
    typedef struct packed {
        aeu_state_t             state;
        logic                   busy;
        logic                   done;
        logic                   mem_req;
        logic [ADDR_W-1:0]      mem_addr;
        logic [ADDR_W-1:0]      pc;
        aeu_mode_t              mode;
        logic [DATA_W-1:0]      idx;
        aeu_inh_t               inh;
        logic [1:0]             cnt;
        logic [1:0]             ptr_n;
        logic [1:0][DATA_W-1:0] opb;
        logic [1:0][DATA_W-1:0] ptb;
        logic [ADDR_W-1:0]      ea;
        logic [DATA_W-1:0]      operand;
        logic [1:0]             nbytes;
        aeu_src_t               src;
        logic [ADDR_W-1:0]      next_pc;
        logic                   bad;
        logic                   wait_req;
        logic                   halt_req;
        logic                   mask_set;
        logic                   mask_clr;
        logic                   sp_reset;
    } aeu_regs_t;

    // Unsigned sum of a base address and an index byte.
    function automatic logic [ADDR_W-1:0] aeu_idx_add(
        input logic [ADDR_W-1:0] base,
        input logic [DATA_W-1:0] idx
    );
        return base + {PAGE0_HI, idx};
    endfunction

    // Program counter plus a signed 8-bit offset.
    function automatic logic [ADDR_W-1:0] aeu_rel(
        input logic [ADDR_W-1:0] pc,
        input logic [DATA_W-1:0] off
    );
        return pc + {{REL_EXT_W{off[DATA_W-1]}}, off};
    endfunction
endpackage
`default_nettype wire

// [verification/aeu_mem_model.sv]
// Memory model that answers the unit's byte reads after a random wait.
`timescale 1ns/1ns
`default_nettype none
module aeu_mem_model
(
    // Clock, reset and read port.
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        req,
    input  wire logic [15:0] addr,
    output var  logic [7:0]  rdata,
    output var  logic        ack
);
    // Contents are a fixed function of the address.
    function automatic logic [7:0] mb(input logic [15:0] a);
        return a[7:0] ^ {a[11:8], a[15:12]} ^ 8'h3c;
    endfunction
    // Ack one cycle at a time; off-ack data is inverted each cycle, so a stale byte shows again every second off-ack cycle.
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ack   <= 1'b0;
            rdata <= 8'h00;
        end
        else if (!ack && req && $urandom_range(2) != 0)
        begin
            ack   <= 1'b1;
            rdata <= mb(addr);
        end
        else
        begin
            ack   <= 1'b0;
            rdata <= ~rdata;
        end
    end
endmodule
`default_nettype wire

// [verification/aeu_top_tb_top.sv]
// Self-checking bench for the effective-address unit.
`timescale 1ns/1ns
`default_nettype none
module aeu_top_tb_top;
    import aeu_pkg::*;
    typedef struct packed {
        logic ck_ea, bad;
        logic [1:0] n, src;
        logic [15:0] ea, npc;
        logic [7:0] op;
        logic [4:0] stb;
    } aeu_exp_t;
    logic        clk, rstn, start, idx_sel, rmw, mem_req, mem_ack, busy, done, bad_mode;
    logic [3:0]  mode;
    logic [2:0]  inh_op;
    logic [15:0] opc_addr, mem_addr, ea, next_pc;
    logic [7:0]  idx_x, idx_y, mem_rdata, operand;
    logic [1:0]  opnd_bytes, ea_src;
    wire  [4:0]  stb;
    int          num_errors, compares, cycles, taken;
    aeu_exp_t    q[$];
    aeu_top DUT (.CLK(clk), .RSTN(rstn), .START(start), .MODE(mode), .INH_OP(inh_op),
        .IDX_SEL(idx_sel), .RMW(rmw), .OPC_ADDR(opc_addr), .IDX_X(idx_x), .IDX_Y(idx_y),
        .MEM_REQ(mem_req), .MEM_ADDR(mem_addr), .MEM_RDATA(mem_rdata), .MEM_ACK(mem_ack),
        .BUSY(busy), .DONE(done), .EA(ea), .OPERAND(operand), .OPND_BYTES(opnd_bytes),
        .EA_SRC(ea_src), .NEXT_PC(next_pc), .BAD_MODE(bad_mode), .WAIT_REQ(stb[4]),
        .HALT_REQ(stb[3]), .MASK_SET(stb[2]), .MASK_CLR(stb[1]), .SP_RESET(stb[0]));
    aeu_mem_model u_mem (.clk(clk), .rst_n(rstn), .req(mem_req), .addr(mem_addr),
        .rdata(mem_rdata), .ack(mem_ack));
    // Expected result of one request, worked out from the mode and memory contents.
    function automatic aeu_exp_t calc(logic [3:0] m, logic [15:0] pc, logic [7:0] ix,
                                      logic rw, logic [2:0] op);
        aeu_exp_t    e;
        logic [7:0]  b1, b2, p0, p1;
        logic [15:0] w;
        b1 = u_mem.mb(pc + 16'h0001);
        b2 = u_mem.mb(pc + 16'h0002);
        p0 = u_mem.mb({8'h00, b1});
        p1 = u_mem.mb({8'h00, b1} + 16'h0001);
        e = '0;
        e.ck_ea = (m != 4'h0);
        e.bad = (m == 4'hf) || (rw && (m == 4'h3 || m == 4'h6 || m == 4'h8 || m == 4'ha));
        e.src = (m == 4'h0) ? 2'h0 : (m == 4'hb || m == 4'hc) ? 2'h3 :
                ((m >= 4'h7 && m <= 4'ha) || m == 4'he) ? 2'h2 : 2'h1;
        e.n = (m == 4'h0 || m == 4'h4 || e.bad) ? 2'h0 : (m == 4'h3 || m == 4'h6) ? 2'h2 : 2'h1;
        case (m)
            4'h1: w = pc + 16'h0001;
            4'h2, 4'hd: w = {8'h00, b1};
            4'h3: w = {b1, b2};
            4'h4: w = {8'h00, ix};
            4'h5: w = {8'h00, b1} + {8'h00, ix};
            4'h6: w = {b1, b2} + {8'h00, ix};
            4'h7, 4'he: w = {8'h00, p0};
            4'h8: w = {p0, p1};
            4'h9: w = {8'h00, p0} + {8'h00, ix};
            4'ha: w = {p0, p1} + {8'h00, ix};
            4'hb: w = pc + 16'h0002 + {{8{b1[7]}}, b1};
            4'hc: w = pc + 16'h0002 + {{8{p0[7]}}, p0};
            default: w = '0;
        endcase
        e.ea = e.bad ? 16'h0000 : w;
        e.npc = pc + 16'h0001 + {14'h0, e.n};
        e.op = (e.n == 2'h0) ? 8'h00 : b1;
        e.stb = (m == 4'h0 && op >= 3'h1 && op <= 3'h5) ? 5'h10 >> (op - 3'h1) : 5'h00;
        return e;
    endfunction
    // Compare one value and count it.
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        compares++;
        if (s !== e)
        begin
            num_errors++;
            $display("BAD %s expected %h seen %h", nm, e, s);
        end
    endtask
    // Print the verdict and end the run.
    task automatic wrap_up();
        if (num_errors == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // Random requests, kept up often back to back; each taken one is noted.
    initial
    begin
        void'($urandom(32'h7fb92e21));
        {rstn, start, mode, inh_op, idx_sel, rmw, opc_addr, idx_x, idx_y} = '0;
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        while (taken < 400)
        begin
            @(posedge clk);
            if (start === 1'b1 && busy === 1'b0)
            begin
                q.push_back(calc(mode, opc_addr, idx_sel ? idx_y : idx_x, rmw, inh_op));
                taken++;
            end
            start    <= (taken < 400) && ($urandom_range(3) != 0);
            mode     <= 4'($urandom);
            inh_op   <= 3'($urandom);
            idx_sel  <= 1'($urandom);
            rmw      <= ($urandom_range(3) == 0);
            opc_addr <= 16'($urandom);
            idx_x    <= 8'($urandom);
            idx_y    <= 8'($urandom);
        end
        repeat (100) @(posedge clk);
        chk("pending", 32'(q.size()), 32'h0);
        wrap_up();
    end
    // Each completion is checked against the oldest note.
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            chk("timeout", 32'h1, 32'h0);
            wrap_up();
        end
        else if (rstn === 1'b1 && done === 1'b1)
        begin
            if (q.size() == 0)
                chk("extra done", 32'h1, 32'h0);
            else
                begin
                    chk("busy", busy, 32'h0);
                    chk("bad_mode", bad_mode, q[0].bad);
                    chk("bytes", opnd_bytes, q[0].n);
                    chk("next_pc", next_pc, q[0].npc);
                    chk("operand", operand, q[0].op);
                    chk("strobes", stb, q[0].stb);
                    if (q[0].ck_ea)
                        chk("ea", ea, q[0].ea);
                    if (!q[0].bad)
                        chk("src", ea_src, q[0].src);
                    void'(q.pop_front());
                end
        end
    end
endmodule
`default_nettype wire
